// *** src/accumulator_feedback_control.v ***
// Purpose: Operand feedback, low-half clear and store saturation control
// Assumes: Core presents one decoded instruction per cycle on the ports below
// Notes:   Register port reads return data one cycle after the read strobe
//          Operand registers are readable high halves only; writes go
//          through the instruction load strobes or the feedback copies, never the register port
//          Accumulators zero and one have no keep-low or saturation bits
`timescale 1ns/1ps
`include "acc_fb_defs.vh"
module accumulator_feedback_control #(
  parameter ACC_W = 40,
  parameter OPD_W = 32
)(
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Register port
  input  wire [3:0]       reg_addr,
  input  wire [15:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [15:0]      reg_rdata,
  // Accumulator writes from the core
  input  wire [ACC_W-1:0] acc_wdata,
  input  wire [2:0]       acc_wsel,
  input  wire             acc_wr_full,
  input  wire             acc_wr_high,
  input  wire             acc_is_arith,
  input  wire [ACC_W-1:0] acc7_wdata,
  input  wire             acc7_wr,
  // Explicit operand loads from the instruction
  input  wire [15:0]      opnd_ldata,
  input  wire             ld_x_high,
  input  wire             ld_x_low,
  input  wire             ld_y_high,
  input  wire             ld_y_low,
  // Accumulator store path
  input  wire [2:0]       st_sel,
  input  wire [1:0]       st_part,
  output reg  [15:0]      st_data,
  // Accumulator file and operand views
  output wire [ACC_W-1:0] acc_six,
  output wire [ACC_W-1:0] acc_seven,
  output reg  [OPD_W-1:0] first_operand,
  output reg  [OPD_W-1:0] second_operand
);

  // ****************************************
  // Control registers
  // ****************************************
  reg  [15:0]      arith_unit_control_one_reg;
  reg  [15:0]      arith_unit_control_zero_reg;
  reg  [ACC_W-1:0] acc_reg [0:7];
  reg  [OPD_W-1:0] first_next;
  reg  [OPD_W-1:0] second_next;
  reg  [ACC_W-1:0] acc_lo_next;
  wire [2:0]       fb_sel;
  wire [5:0]       keep_low_half;
  wire [5:0]       sat_disable;
  wire             dual_load;
  wire             low_clear_mode;
  wire             arith6;
  wire             arith6_high;
  wire             arith7;
  wire [15:0]      hi6;
  wire [15:0]      hi7;
  wire [ACC_W-1:0] st_raw;
  wire [ACC_W-1:0] st_sat;
  wire             st_sat_en;
  integer          i;

  // Field views of the two control registers
  assign fb_sel         = arith_unit_control_one_reg[`FBSEL_HI:`FBSEL_LO];
  assign keep_low_half  = arith_unit_control_one_reg[`KEEPLOW_HI:`KEEPLOW_LO];
  assign sat_disable    = arith_unit_control_one_reg[`SATDIS_HI:`SATDIS_LO];
  assign dual_load      = arith_unit_control_zero_reg[`DUAL_LOAD_BIT];
  assign low_clear_mode = ~arith_unit_control_zero_reg[`LOW_CLEAR_BIT];

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      arith_unit_control_one_reg <= `ARITH_UNIT_CONTROL_ONE_RESET;
      arith_unit_control_zero_reg <= `ARITH_UNIT_CONTROL_ZERO_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ARITH_UNIT_CONTROL_ONE_ADDR)
        arith_unit_control_one_reg <= reg_wdata & `ARITH_UNIT_CONTROL_ONE_WMASK;
      if (reg_addr == `ARITH_UNIT_CONTROL_ZERO_ADDR)
        arith_unit_control_zero_reg <= reg_wdata;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ARITH_UNIT_CONTROL_ONE_ADDR: reg_rdata <= arith_unit_control_one_reg;
        `ARITH_UNIT_CONTROL_ZERO_ADDR: reg_rdata <= arith_unit_control_zero_reg;
        `OPND_X_ADDR: reg_rdata <= first_operand[OPD_W-1:16];
        `OPND_Y_ADDR: reg_rdata <= second_operand[OPD_W-1:16];
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // ****************************************
  // Accumulator file
  // ****************************************
  // Only accumulators two to seven have keep-low bits; others always clear low
  // A full write wins over a high-half write in the same cycle
  // The dual-result port to accumulator seven is applied last, so it wins
  // over a normal write that also selects accumulator seven
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 8; i = i + 1)
        acc_reg[i] <= {ACC_W{1'b0}};
    end
    else
    begin
      if (acc_wr_full)
        acc_reg[acc_wsel] <= acc_wdata;
      else if (acc_wr_high)
        acc_reg[acc_wsel] <= acc_lo_next;
      if (acc7_wr)
        acc_reg[7] <= acc7_wdata;
    end
  end

  always @*
  begin
    acc_lo_next = {acc_wdata[ACC_W-1:16], acc_reg[acc_wsel][15:0]};
    if (acc_wsel < 3'h2)
      acc_lo_next[15:0] = 16'h0000;
    else if (!keep_low_half[acc_wsel - 3'h2])
      acc_lo_next[15:0] = 16'h0000;
  end

  assign acc_six   = acc_reg[6];
  assign acc_seven = acc_reg[7];

  // ****************************************
  // Feedback decode
  // ****************************************
  assign arith6      = acc_is_arith && (acc_wsel == 3'h6) && (acc_wr_full || acc_wr_high);
  assign arith6_high = arith6;
  assign arith7      = acc_is_arith && acc7_wr;
  assign hi6         = acc_wdata[31:16];
  assign hi7         = acc7_wdata[31:16];

  // Next operand values are built in three layers, lowest priority first:
  // explicit second operand loads with their dual-load mirror, then the
  // feedback copies, then explicit loads again so the instruction wins
  // for every half that it names
  always @*
  begin
    first_next  = first_operand;
    second_next = second_operand;
    // Dual load mode copies second operand loads into the first operand
    if (ld_y_high)
    begin
      second_next[31:16] = opnd_ldata;
      if (dual_load)
        first_next[31:16] = opnd_ldata;
      if (low_clear_mode && !ld_y_low)
      begin
        second_next[15:0] = 16'h0000;
        if (dual_load)
          first_next[15:0] = 16'h0000;
      end
    end
    if (ld_y_low)
    begin
      second_next[15:0] = opnd_ldata;
      if (dual_load)
        first_next[15:0] = opnd_ldata;
    end
    // Feedback copies; only arithmetic results reach this point
    case (fb_sel)
      `FB_X_FULL:
      begin
        if (arith6 && acc_wr_full)
          first_next = acc_wdata[31:0];
        if (arith6 && acc_wr_high && !acc_wr_full)
          first_next[31:16] = hi6;
      end
      `FB_X_HIGH:
      begin
        if (arith6_high)
          first_next[31:16] = hi6;
      end
      `FB_X_SPLIT:
      begin
        if (arith6_high)
          first_next[31:16] = hi6;
        if (arith7)
          first_next[15:0] = hi7;
      end
      `FB_Y_FULL:
      begin
        if (arith6 && acc_wr_full)
        begin
          second_next = acc_wdata[31:0];
          if (dual_load)
            first_next = acc_wdata[31:0];
        end
        else if (arith6)
        begin
          second_next[31:16] = hi6;
          if (dual_load)
            first_next[31:16] = hi6;
        end
      end
      `FB_Y_HIGH:
      begin
        if (arith6_high)
        begin
          second_next[31:16] = hi6;
          if (dual_load)
            first_next[31:16] = hi6;
          if (low_clear_mode)
          begin
            second_next[15:0] = 16'h0000;
            if (dual_load)
              first_next[15:0] = 16'h0000;
          end
        end
      end
      `FB_Y_SPLIT:
      begin
        if (arith6_high)
        begin
          second_next[31:16] = hi6;
          if (dual_load)
            first_next[31:16] = hi6;
          if (low_clear_mode && !arith7)
            second_next[15:0] = 16'h0000;
        end
        if (arith7)
        begin
          second_next[15:0] = hi7;
          if (dual_load)
            first_next[15:0] = hi7;
        end
      end
      default:
      begin
        first_next  = first_next;
        second_next = second_next;
      end
    endcase
    // Explicit instruction loads win over feedback for the same portion
    if (ld_x_high)
      first_next[31:16] = opnd_ldata;
    if (ld_x_low)
      first_next[15:0] = opnd_ldata;
    if (ld_y_high)
      second_next[31:16] = opnd_ldata;
    if (ld_y_low)
      second_next[15:0] = opnd_ldata;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      first_operand  <= {OPD_W{1'b0}};
      second_operand <= {OPD_W{1'b0}};
    end
    else
    begin
      first_operand  <= first_next;
      second_operand <= second_next;
    end
  end

  // ****************************************
  // Store path with saturation
  // ****************************************
  // The saturated value feeds only the store port; the accumulator file
  // keeps its full guard-bit contents
  assign st_raw    = acc_reg[st_sel];
  assign st_sat_en = (st_sel >= 3'h2) && !sat_disable[st_sel - 3'h2];

  acc_saturate #(
    .ACC_W   (ACC_W)
  ) u_sat (
    .acc_in  (st_raw),
    .sat_en  (st_sat_en),
    .acc_out (st_sat)
  );

  always @(posedge clk)
  begin
    if (!rst_n)
      st_data <= 16'h0000;
    else
    begin
      // Part 2 returns the guard bits sign-extended to a word
      case (st_part)
        2'h0: st_data <= st_sat[15:0];
        2'h1: st_data <= st_sat[31:16];
        2'h2: st_data <= {{(16-(ACC_W-32)){st_sat[ACC_W-1]}}, st_sat[ACC_W-1:32]};
        default: st_data <= 16'h0000;
      endcase
    end
  end

endmodule

// *** pkg/acc_fb_defs.vh ***
// Purpose: Constants for the arithmetic-unit control registers and feedback logic
// Assumes: Included by the feedback control design files
// Notes:   Definitions only
`ifndef ACC_FB_DEFS_VH
`define ACC_FB_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define ARITH_UNIT_CONTROL_ONE_ADDR        4'h0
`define ARITH_UNIT_CONTROL_ZERO_ADDR        4'h1
`define OPND_X_ADDR      4'h2
`define OPND_Y_ADDR      4'h3
`define ARITH_UNIT_CONTROL_ONE_RESET       16'h0000
`define ARITH_UNIT_CONTROL_ZERO_RESET       16'h0000
`define ARITH_UNIT_CONTROL_ONE_WMASK       16'h7FFF

// ****************************************
// Field positions
// ****************************************
`define FBSEL_HI         14
`define FBSEL_LO         12
`define KEEPLOW_HI       11
`define KEEPLOW_LO       6
`define SATDIS_HI        5
`define SATDIS_LO        0
`define DUAL_LOAD_BIT    7
`define LOW_CLEAR_BIT    6

// ****************************************
// Feedback selector codes
// ****************************************
`define FB_NONE          3'h0
`define FB_X_FULL        3'h1
`define FB_X_HIGH        3'h2
`define FB_X_SPLIT       3'h3
`define FB_RESERVED      3'h4
`define FB_Y_FULL        3'h5
`define FB_Y_HIGH        3'h6
`define FB_Y_SPLIT       3'h7

`endif

// *** src/acc_saturate.v ***
// Purpose: 32-bit saturation of a 40-bit accumulator value for stores
// Assumes: Accumulator is two's complement, 40 bits with 8 guard bits
// Notes:   Combinational; accumulator itself is never changed
`timescale 1ns/1ps
module acc_saturate #(
  parameter ACC_W = 40
)(
  // Value and control
  input  wire [ACC_W-1:0] acc_in,
  input  wire             sat_en,
  // Result
  output wire [ACC_W-1:0] acc_out
);
  wire over;
  wire [ACC_W-1:0] pos_lim;
  wire [ACC_W-1:0] neg_lim;

  // Overflow when the guard bits are not a sign extension of bit 31
  assign over    = ~(&acc_in[ACC_W-1:31] | ~(|acc_in[ACC_W-1:31]));
  assign pos_lim = {{(ACC_W-31){1'b0}}, {31{1'b1}}};
  assign neg_lim = {{(ACC_W-31){1'b1}}, {31{1'b0}}};
  assign acc_out = (sat_en && over) ? (acc_in[ACC_W-1] ? neg_lim : pos_lim) : acc_in;
endmodule

// *** dv/acc_fb_checker_assertions.sv ***
// Purpose: Port-level checks of operand feedback, low clear and store saturation
// Assumes: Control registers change only through the register port
// Notes:   Shadow copies of both control registers are kept here
`timescale 1ns/1ps
`include "acc_fb_defs.vh"
module acc_fb_checker #(
  parameter ACC_W = 40,
  parameter OPD_W = 32
)(
  // Clock and reset
  input wire             clk,
  input wire             rst_n,
  // Register port
  input wire [3:0]       reg_addr,
  input wire [15:0]      reg_wdata,
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [15:0]      reg_rdata,
  // Core side
  input wire [ACC_W-1:0] acc_wdata,
  input wire [2:0]       acc_wsel,
  input wire             acc_wr_full,
  input wire             acc_wr_high,
  input wire             acc_is_arith,
  input wire [ACC_W-1:0] acc7_wdata,
  input wire             acc7_wr,
  input wire [15:0]      opnd_ldata,
  input wire             ld_x_high,
  input wire             ld_x_low,
  input wire             ld_y_high,
  input wire             ld_y_low,
  input wire [2:0]       st_sel,
  input wire [1:0]       st_part,
  input wire [15:0]      st_data,
  input wire [ACC_W-1:0] acc_six,
  input wire [OPD_W-1:0] first_operand,
  input wire [OPD_W-1:0] second_operand
);
  reg  [15:0]      c1_reg;
  reg  [15:0]      c0_reg;
  reg  [ACC_W-1:0] d6_reg;
  reg  [ACC_W-1:0] d7_reg;
  wire [2:0]       fb  = c1_reg[14:12];
  wire             a6  = acc_is_arith && acc_wsel == 3'h6 && (acc_wr_full || acc_wr_high);
  wire             nox = !ld_x_high && !ld_x_low;
  wire             noy = !ld_y_high && !ld_y_low;

  always @(posedge clk)
  begin
    d6_reg <= acc_wdata;
    d7_reg <= acc7_wdata;
    if (!rst_n)
    begin
      c1_reg <= 16'h0000;
      c0_reg <= 16'h0000;
    end
    else if (reg_wr && reg_addr == `ARITH_UNIT_CONTROL_ONE_ADDR)
      c1_reg <= reg_wdata & 16'h7FFF;
    else if (reg_wr && reg_addr == `ARITH_UNIT_CONTROL_ZERO_ADDR)
      c0_reg <= reg_wdata;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Arithmetic write to accumulator six under a first operand code
  sequence x_fb(c);
    fb == c && a6 && nox;
  endsequence

  AST_X_FULL: assert property (x_fb(3'h1) ##0 acc_wr_full |=>
    first_operand == d6_reg[31:0]) else $error("x full feedback wrong");
  AST_X_HIGH: assert property (x_fb(3'h2) |=>
    first_operand[31:16] == d6_reg[31:16]) else $error("x high feedback wrong");
  AST_X_SPLIT: assert property (x_fb(3'h3) ##0 acc7_wr |=>
    first_operand == {d6_reg[31:16], d7_reg[31:16]}) else $error("x split feedback wrong");
  AST_MOVE_NO_FB: assert property ((acc_wr_full || acc_wr_high || acc7_wr) &&
    !acc_is_arith && nox && noy |=> $stable(first_operand) && $stable(second_operand))
    else $error("move changed an operand");
  AST_LOAD_WINS: assert property (ld_x_high |=>
    first_operand[31:16] == $past(opnd_ldata)) else $error("explicit load lost");
  AST_Y_TO_X: assert property (c0_reg[7] && fb == 3'h5 && a6 && acc_wr_full && nox && noy
    |=> second_operand == d6_reg[31:0] && first_operand == d6_reg[31:0])
    else $error("dual load mirror wrong");
  AST_YH_CLEAR: assert property (!c0_reg[6] && fb == 3'h6 && a6 && noy |=>
    second_operand == {d6_reg[31:16], 16'h0000}) else $error("y low not cleared");
  AST_Y_SPLIT: assert property (!c0_reg[6] && fb == 3'h7 && a6 && noy |=>
    second_operand == {d6_reg[31:16], $past(acc7_wr) ? d7_reg[31:16] : 16'h0000})
    else $error("y split feedback wrong");
  AST_KEEP_LOW: assert property (acc_wr_high && !acc_wr_full && acc_wsel == 3'h6 &&
    !c1_reg[10] |=> acc_six == {d6_reg[ACC_W-1:16], 16'h0000}) else $error("low half kept");
  AST_SAT_HIGH: assert property (st_sel == 3'h6 && st_part == 2'h1 && !c1_reg[4] &&
    !acc_six[ACC_W-1] && acc_six[ACC_W-1:31] != 0 |=> st_data == 16'h7FFF)
    else $error("store not saturated");
  AST_CTL_READ: assert property (reg_rd && reg_addr == `ARITH_UNIT_CONTROL_ONE_ADDR |=>
    reg_rdata == $past(c1_reg)) else $error("control read wrong");
endmodule

bind accumulator_feedback_control acc_fb_checker #(.ACC_W(ACC_W), .OPD_W(OPD_W)) chk_u (.*);

// *** dv/accumulator_feedback_control_tb.sv ***
// Purpose: Directed register and datapath test of the feedback control block
// Assumes: Outputs settle within 1 ns of the capturing edge
// Notes:   Explicit operand load data is held at one value
`timescale 1ns/1ps
`include "acc_fb_defs.vh"
module accumulator_feedback_control_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [39:0] acc_wdata = 40'h0;
  reg  [2:0]  acc_wsel = 3'h0;
  reg         acc_wr_full = 1'b0;
  reg         acc_wr_high = 1'b0;
  reg         acc_is_arith = 1'b0;
  reg  [39:0] acc7_wdata = 40'h0;
  reg         acc7_wr = 1'b0;
  reg  [3:0]  ld = 4'h0;
  reg  [2:0]  st_sel = 3'h0;
  reg  [1:0]  st_part = 2'h0;
  wire [15:0] reg_rdata;
  wire [15:0] st_data;
  wire [39:0] acc_six;
  wire [31:0] x_op;
  wire [31:0] y_op;
  integer     bad_count = 0;
  integer     total_checks = 0;
  localparam [39:0] D = 40'h1287654321;
  localparam [39:0] E = 40'h00ABCD1357;

  accumulator_feedback_control dut_u (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_wdata(acc_wdata), .acc_wsel(acc_wsel),
    .acc_wr_full(acc_wr_full), .acc_wr_high(acc_wr_high), .acc_is_arith(acc_is_arith),
    .acc7_wdata(acc7_wdata), .acc7_wr(acc7_wr), .opnd_ldata(16'hBEEF), .ld_x_high(ld[3]),
    .ld_x_low(ld[2]), .ld_y_high(ld[1]), .ld_y_low(ld[0]), .st_sel(st_sel),
    .st_part(st_part), .st_data(st_data), .acc_six(acc_six), .acc_seven(),
    .first_operand(x_op), .second_operand(y_op));

  always #12.5 clk = ~clk;

  task finish_test;
  begin
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  task chk(input string n, input [39:0] e, input [39:0] g);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("Error %0s expected %h seen %h", n, e, g);
    end
  end
  endtask

  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask

  task rd(input [3:0] a, input [15:0] e);
  begin
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {24'h0, e}, {24'h0, reg_rdata});
  end
  endtask

  task ctl(input [2:0] c, input [11:0] b);
    wr(`ARITH_UNIT_CONTROL_ONE_ADDR, {1'b0, c, b});
  endtask

  task op(input [1:0] w, input ar, input a7, input [3:0] l, input [39:0] d, input [39:0] d7);
  begin
    @(posedge clk);
    acc_wsel <= 3'h6;
    {acc_wr_full, acc_wr_high} <= w;
    acc_is_arith <= ar;
    acc7_wr <= a7;
    ld <= l;
    acc_wdata <= d;
    acc7_wdata <= d7;
    @(posedge clk);
    {acc_wr_full, acc_wr_high, acc7_wr, ld} <= 7'h00;
    #1;
  end
  endtask

  task st(input [1:0] p, input [15:0] e);
  begin
    @(posedge clk);
    st_sel <= 3'h6;
    st_part <= p;
    @(posedge clk);
    #1 chk("st_data", {24'h0, e}, {24'h0, st_data});
  end
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count = bad_count + 1;
    finish_test;
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ARITH_UNIT_CONTROL_ONE_ADDR, 16'h0000);
    wr(`ARITH_UNIT_CONTROL_ONE_ADDR, 16'hFFFF);
    rd(`ARITH_UNIT_CONTROL_ONE_ADDR, 16'h7FFF);
    rd(4'hF, 16'h0000);
    ctl(`FB_X_FULL, 12'hFFF);
    op(2'h2, 1'b1, 1'b0, 4'h0, D, E);
    chk("x_op", 40'h0087654321, {8'h00, x_op});
    rd(`OPND_X_ADDR, 16'h8765);
    op(2'h2, 1'b0, 1'b0, 4'h0, E, E);
    chk("x_op", 40'h0087654321, {8'h00, x_op});
    ctl(`FB_X_HIGH, 12'hFFF);
    op(2'h1, 1'b1, 1'b0, 4'h0, E, E);
    chk("x_op", 40'h00ABCD4321, {8'h00, x_op});
    op(2'h1, 1'b1, 1'b0, 4'h8, D, E);
    chk("x_op", 40'h00BEEF4321, {8'h00, x_op});
    ctl(`FB_X_SPLIT, 12'hFFF);
    op(2'h1, 1'b1, 1'b1, 4'h0, D, E);
    chk("x_op", 40'h008765ABCD, {8'h00, x_op});
    ctl(`FB_RESERVED, 12'hFFF);
    op(2'h2, 1'b1, 1'b0, 4'h0, E, E);
    chk("x_op", 40'h008765ABCD, {8'h00, x_op});
    wr(`ARITH_UNIT_CONTROL_ZERO_ADDR, 16'h00C0);
    ctl(`FB_X_FULL, 12'hFFF);
    op(2'h2, 1'b1, 1'b0, 4'h2, E, E);
    chk("x_op", 40'h00ABCD1357, {8'h00, x_op});
    ctl(`FB_Y_FULL, 12'hFFF);
    op(2'h2, 1'b1, 1'b0, 4'h0, D, E);
    chk("y_op", 40'h0087654321, {8'h00, y_op});
    chk("x_op", 40'h0087654321, {8'h00, x_op});
    wr(`ARITH_UNIT_CONTROL_ZERO_ADDR, 16'h0000);
    ctl(`FB_Y_HIGH, 12'hFFF);
    op(2'h1, 1'b1, 1'b0, 4'h0, E, E);
    chk("y_op", 40'h00ABCD0000, {8'h00, y_op});
    rd(`OPND_Y_ADDR, 16'hABCD);
    ctl(`FB_Y_SPLIT, 12'hFFF);
    op(2'h1, 1'b1, 1'b1, 4'h0, D, E);
    chk("y_op", 40'h008765ABCD, {8'h00, y_op});
    op(2'h1, 1'b1, 1'b0, 4'h0, E, E);
    chk("y_op", 40'h00ABCD0000, {8'h00, y_op});
    ctl(`FB_NONE, 12'hBFF);
    op(2'h2, 1'b0, 1'b0, 4'h0, D, E);
    op(2'h1, 1'b0, 1'b0, 4'h0, E, E);
    chk("acc_six", 40'h00ABCD0000, acc_six);
    ctl(`FB_NONE, 12'hFFF);
    op(2'h2, 1'b0, 1'b0, 4'h0, E, E);
    op(2'h1, 1'b0, 1'b0, 4'h0, D, E);
    chk("acc_six", 40'h1287651357, acc_six);
    ctl(`FB_NONE, 12'hFEF);
    st(2'h1, 16'h7FFF);
    st(2'h0, 16'hFFFF);
    chk("acc_six", 40'h1287651357, acc_six);
    ctl(`FB_NONE, 12'hFFF);
    st(2'h1, 16'h8765);
    finish_test;
  end
endmodule
